/* dsdl_regs.vh */
// Constants for the strobe delay loop control block.
`ifndef DSDL_REGS_VH
`define DSDL_REGS_VH
`define DSDL_CODE_W        8
`define DSDL_CODE_MAX      8'hff
`define DSDL_CODE_MIN      8'h00
`define DSDL_CODE_RESET    8'h80
`define DSDL_OFFSET_W      6
`define DSDL_GRADE_W       2
`define DSDL_TIMING_W      4
`define DSDL_PHASE_72      1'b0
`define DSDL_PHASE_90      1'b1
`define DSDL_LOCK_WAIT_CYC 336
`endif

/* dsdl_loop.v */
// One delay-locked loop: counter, load, freeze, offset and status flags.
`include "dsdl_regs.vh"
module dsdl_loop #(
   parameter CODE_W = `DSDL_CODE_W
) (
   // Clock and reset
   input  wire              clock,
   input  wire              reset_n,
   // Control
   input  wire              loop_enable,
   input  wire              loop_force_load,
   input  wire [CODE_W-1:0] load_delay,
   input  wire [5:0]        fine_offset,
   // Phase comparator result: high means the line is too short
   input  wire              phase_late,
   // Results
   output reg  [CODE_W-1:0] line_code_reg,
   output reg  [CODE_W-1:0] loop_counter_value_reg,
   output reg               overflow_reg,
   output reg               underflow_reg
);
   reg  [CODE_W-1:0] counter_next;
   reg  [9:0]        sum;
   reg               en_d_reg;

   always @* begin
      counter_next = loop_counter_value_reg;
      if (loop_enable) begin
         if (loop_force_load && en_d_reg)
            counter_next = load_delay; // R10 R11
         else if (!loop_force_load) begin
            if (phase_late && loop_counter_value_reg != `DSDL_CODE_MAX)
               counter_next = loop_counter_value_reg + 8'h01; // R18
            else if (!phase_late &&
                     loop_counter_value_reg != `DSDL_CODE_MIN)
               counter_next = loop_counter_value_reg - 8'h01; // R18
         end
      end
      // Offset is a signed step added to the code, clamped to range.
      sum = {2'b00, loop_counter_value_reg} +
            {{4{fine_offset[5]}}, fine_offset}; // R14
      if (sum[9])
         sum = 10'h000;
      else if (sum[8])
         sum = 10'h0ff;
   end

   always @(posedge clock) begin
      if (!reset_n) begin
         loop_counter_value_reg <= `DSDL_CODE_RESET;
         line_code_reg          <= `DSDL_CODE_RESET;
         overflow_reg           <= 1'b0;
         underflow_reg          <= 1'b0;
         en_d_reg               <= 1'b0;
      end else begin
         en_d_reg               <= loop_enable;
         loop_counter_value_reg <= counter_next; // R9
         line_code_reg          <= sum[7:0]; // R5
         if (!loop_enable) begin
            overflow_reg  <= 1'b0; // R16
            underflow_reg <= 1'b0; // R16
         end else begin
            if (loop_counter_value_reg == `DSDL_CODE_MAX)
               overflow_reg <= 1'b1; // R15
            if (loop_counter_value_reg == `DSDL_CODE_MIN)
               underflow_reg <= 1'b1; // R15
         end
      end
   end
endmodule // dsdl_loop

/* dsdl_top.v */
// Strobe delay loop control: read and write loops plus timing-set choice.
// Summary of operation
// R1 - Two-bit grade field picks one of four timing configurations.
// R2 - Four sets each for standard and mobile memory, chosen by memory type.
// R3 - Timing parameters are whole interface clock cycle counts.
// R4 - Two independent loops: one for reads, one for writes.
// R5 - Each loop continuously outputs an 8-bit delay code.
// R6 - Read loop drives upper and lower byte strobe delay lines.
// R7 - Write loop drives one delay line for outgoing write data.
// R8 - Phase select picks 72 or 90 degree nominal delay.
// R9 - Disabled loop freezes its counter; re-enable resumes from it.
// R10 - Load copies delay field into counter after two enabled cycles.
// R11 - Held load keeps forcing the delay value: unlocked mode.
// R12 - Software sets enable, load, value, then clears enable.
// R13 - Software loads 128, clears load, waits 336 cycles before access.
// R14 - Six-bit signed offsets, +31 to -32, added to loop delay.
// R15 - Counter value shown; overflow at 255, underflow at 0 flagged.
// R16 - Both flags clear when the loop is disabled.
// R17 - Software uses unlocked mode, value 104, below minimum frequency.
// R18 - Tracking steps counter by one per cycle, saturating at 0 and 255.
`include "dsdl_regs.vh"
module dsdl_top #(
   parameter CODE_W   = `DSDL_CODE_W,
   parameter TIMING_W = `DSDL_TIMING_W,
   parameter LOCK_WAIT_CYC = `DSDL_LOCK_WAIT_CYC
) (
   // Clock and reset
   input  wire                clock,
   input  wire                reset_n,
   // Memory timing selection
   input  wire [1:0]          timing_grade_select,
   input  wire                mobile_ddr_select,
   // Loop control, shared except the per-loop read and write fine offsets
   input  wire                loop_enable,
   input  wire                loop_force_load,
   input  wire                phase_select_bit,
   input  wire [CODE_W-1:0]   load_delay,
   input  wire [5:0]          read_fine_offset,
   input  wire [5:0]          write_fine_offset,
   // Phase detector pins from the delay replicas
   input  wire                read_phase_late_pin,
   input  wire                write_phase_late_pin,
   // Delay line codes and phase select
   output reg  [CODE_W-1:0]   upper_strobe_code,
   output reg  [CODE_W-1:0]   lower_strobe_code,
   output reg  [CODE_W-1:0]   write_data_code,
   output reg                 loop_phase_select,
   // Read loop status
   output reg  [CODE_W-1:0]   read_loop_status_count,
   output reg                 read_loop_status_ovf,
   output reg                 read_loop_status_unf,
   // Write loop status
   output reg  [CODE_W-1:0]   write_loop_status_count,
   output reg                 write_loop_status_ovf,
   output reg                 write_loop_status_unf,
   // Selected timing set, in interface clock cycles
   output reg  [TIMING_W-1:0] t_ras_cyc,
   output reg  [TIMING_W-1:0] t_rc_cyc,
   output reg  [TIMING_W-1:0] t_rfc_cyc,
   output reg  [TIMING_W-1:0] t_rcd_cyc,
   output reg  [TIMING_W-1:0] t_rp_cyc,
   output reg  [TIMING_W-1:0] t_wr_cyc,
   // Lock wait elapsed since tracking started
   output reg                 lock_wait_done
);
   reg  [2:0]  rd_sync_reg;
   reg  [2:0]  wr_sync_reg;
   reg         rd_late_reg;
   reg         wr_late_reg;
   reg  [8:0]  lock_cnt_reg;
   wire [CODE_W-1:0] rd_code;
   wire [CODE_W-1:0] wr_code;
   wire [CODE_W-1:0] rd_cnt;
   wire [CODE_W-1:0] wr_cnt;
   wire rd_ovf;
   wire rd_unf;
   wire wr_ovf;
   wire wr_unf;

   // Cycle counts per timing set; index is {mobile, grade}.
   function [6*TIMING_W-1:0] timing_set;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: timing_set = {4'h5, 4'h7, 4'h8, 4'h2, 4'h2, 4'h2};
            3'h1: timing_set = {4'h5, 4'h8, 4'h9, 4'h2, 4'h2, 4'h2};
            3'h2: timing_set = {4'h6, 4'h9, 4'ha, 4'h3, 4'h3, 4'h2};
            3'h3: timing_set = {4'h7, 4'ha, 4'hc, 4'h3, 4'h3, 4'h2};
            3'h4: timing_set = {4'h3, 4'h4, 4'h5, 4'h1, 4'h1, 4'h1};
            3'h5: timing_set = {4'h4, 4'h6, 4'h7, 4'h2, 4'h2, 4'h1};
            3'h6: timing_set = {4'h5, 4'h7, 4'h8, 4'h2, 4'h2, 4'h2};
            default: timing_set = {4'h6, 4'h9, 4'ha, 4'h3, 4'h3, 4'h2};
         endcase
      end
   endfunction

   wire [6*TIMING_W-1:0] tsel =
      timing_set({mobile_ddr_select, timing_grade_select}); // R1 R2

   // Phase detector pins pass three flops; change accepted on agreement.
   always @(posedge clock) begin
      if (!reset_n) begin
         rd_sync_reg <= 3'h0;
         wr_sync_reg <= 3'h0;
         rd_late_reg <= 1'b0;
         wr_late_reg <= 1'b0;
      end else begin
         rd_sync_reg <= {rd_sync_reg[1:0], read_phase_late_pin};
         wr_sync_reg <= {wr_sync_reg[1:0], write_phase_late_pin};
         if (rd_sync_reg[1] == rd_sync_reg[2])
            rd_late_reg <= rd_sync_reg[2];
         if (wr_sync_reg[1] == wr_sync_reg[2])
            wr_late_reg <= wr_sync_reg[2];
      end
   end

   dsdl_loop #(.CODE_W(CODE_W)) u_read_loop ( // R4
      .clock                  (clock),
      .reset_n                (reset_n),
      .loop_enable            (loop_enable),
      .loop_force_load        (loop_force_load),
      .load_delay             (load_delay),
      .fine_offset            (read_fine_offset),
      .phase_late             (rd_late_reg),
      .line_code_reg          (rd_code),
      .loop_counter_value_reg (rd_cnt),
      .overflow_reg           (rd_ovf),
      .underflow_reg          (rd_unf)
   );

   dsdl_loop #(.CODE_W(CODE_W)) u_write_loop ( // R4
      .clock                  (clock),
      .reset_n                (reset_n),
      .loop_enable            (loop_enable),
      .loop_force_load        (loop_force_load),
      .load_delay             (load_delay),
      .fine_offset            (write_fine_offset),
      .phase_late             (wr_late_reg),
      .line_code_reg          (wr_code),
      .loop_counter_value_reg (wr_cnt),
      .overflow_reg           (wr_ovf),
      .underflow_reg          (wr_unf)
   );

   always @(posedge clock) begin
      if (!reset_n) begin
         upper_strobe_code       <= `DSDL_CODE_RESET;
         lower_strobe_code       <= `DSDL_CODE_RESET;
         write_data_code         <= `DSDL_CODE_RESET;
         loop_phase_select       <= `DSDL_PHASE_72;
         read_loop_status_count  <= `DSDL_CODE_RESET;
         read_loop_status_ovf    <= 1'b0;
         read_loop_status_unf    <= 1'b0;
         write_loop_status_count <= `DSDL_CODE_RESET;
         write_loop_status_ovf   <= 1'b0;
         write_loop_status_unf   <= 1'b0;
         t_ras_cyc               <= {TIMING_W{1'b0}};
         t_rc_cyc                <= {TIMING_W{1'b0}};
         t_rfc_cyc               <= {TIMING_W{1'b0}};
         t_rcd_cyc               <= {TIMING_W{1'b0}};
         t_rp_cyc                <= {TIMING_W{1'b0}};
         t_wr_cyc                <= {TIMING_W{1'b0}};
         lock_cnt_reg            <= 9'h000;
         lock_wait_done          <= 1'b0;
      end else begin
         upper_strobe_code       <= rd_code; // R6
         lower_strobe_code       <= rd_code; // R6
         write_data_code         <= wr_code; // R7
         loop_phase_select       <= phase_select_bit; // R8
         read_loop_status_count  <= rd_cnt; // R15
         read_loop_status_ovf    <= rd_ovf; // R15
         read_loop_status_unf    <= rd_unf; // R15
         write_loop_status_count <= wr_cnt; // R15
         write_loop_status_ovf   <= wr_ovf; // R15
         write_loop_status_unf   <= wr_unf; // R15
         t_ras_cyc <= tsel[6*TIMING_W-1:5*TIMING_W]; // R3
         t_rc_cyc  <= tsel[5*TIMING_W-1:4*TIMING_W]; // R3
         t_rfc_cyc <= tsel[4*TIMING_W-1:3*TIMING_W]; // R3
         t_rcd_cyc <= tsel[3*TIMING_W-1:2*TIMING_W]; // R3
         t_rp_cyc  <= tsel[2*TIMING_W-1:TIMING_W]; // R3
         t_wr_cyc  <= tsel[TIMING_W-1:0]; // R3
         // Counts tracking cycles so software can poll for lock wait.
         if (!loop_enable || loop_force_load) begin
            lock_cnt_reg   <= 9'h000;
            lock_wait_done <= 1'b0;
         end else if (lock_cnt_reg == LOCK_WAIT_CYC[8:0]) begin
            lock_wait_done <= 1'b1; // R13
         end else begin
            lock_cnt_reg <= lock_cnt_reg + 9'h001;
         end
      end
   end
endmodule // dsdl_top

/* dsdl_phase_model.sv */
// Phase detector replica: reports late while the delay code is short.
module dsdl_phase_model (
   input  wire logic       clock,
   input  wire logic [7:0] code,
   input  wire logic [7:0] target,
   output logic            late
);
   timeunit 1ns;
   timeprecision 1ps;
   initial late = 1'b0;
   always @(posedge clock) begin
      late <= code < target;
   end
endmodule // dsdl_phase_model

/* dsdl_assertions.sv */
// Checker for the strobe delay loop control block.
module dsdl_assertions (
   input wire logic       clock, reset_n, loop_enable, loop_force_load,
   input wire logic       phase_select_bit, loop_phase_select,
   input wire logic [7:0] load_delay, upper_strobe_code, lower_strobe_code,
   input wire logic [7:0] read_loop_status_count, write_loop_status_count,
   input wire logic       read_loop_status_ovf, read_loop_status_unf,
   input wire logic       write_loop_status_ovf, write_loop_status_unf
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   wire trk = loop_enable && !loop_force_load;
   strobe_pair_a: assert property (upper_strobe_code == lower_strobe_code)
      else $error("strobe codes differ");
   phase_copy_a: assert property ($past(reset_n) |->
      loop_phase_select == $past(phase_select_bit))
      else $error("phase select not followed");
   load_copy_a: assert property (loop_enable && $past(loop_enable)
      && loop_force_load |-> ##2 read_loop_status_count ==
      $past(load_delay, 2) && write_loop_status_count == $past(load_delay, 2))
      else $error("load value not taken");
   counter_freeze_a: assert property ((!loop_enable)[*3] |=>
      $stable(read_loop_status_count) && $stable(write_loop_status_count))
      else $error("disabled counter moved");
   flags_clear_a: assert property ((!loop_enable)[*3] |->
      !read_loop_status_ovf && !read_loop_status_unf
      && !write_loop_status_ovf && !write_loop_status_unf)
      else $error("flags set while disabled");
   step_one_a: assert property (trk[*3] |=> (read_loop_status_count -
      $past(read_loop_status_count)) inside {8'h00, 8'h01, 8'hff})
      else $error("counter step larger than one");
   sat_top_a: assert property (trk && read_loop_status_count == 8'hff
      |=> read_loop_status_count != 8'h00)
      else $error("counter wrapped at top");
   ovf_set_a: assert property (loop_enable[*2] ##1 (loop_enable &&
      read_loop_status_count == 8'hff) ##1 loop_enable[*2]
      |-> read_loop_status_ovf)
      else $error("overflow flag missed");
   unf_set_a: assert property (loop_enable[*2] ##1 (loop_enable &&
      write_loop_status_count == 8'h00) ##1 loop_enable[*2]
      |-> write_loop_status_unf)
      else $error("underflow flag missed");
endmodule // dsdl_assertions
bind dsdl_top dsdl_assertions i_dsdl_assertions (.*);

/* testbench.sv */
// Testbench for the strobe delay loop control block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, reset_n = 1'b0, mobile_ddr_select = 1'b1;
   logic loop_enable = 1'b0, loop_force_load = 1'b0, phase_select_bit = 1'b0;
   logic [1:0] timing_grade_select = 2'h0;
   logic [7:0] load_delay = 8'h80, rd_target = 8'h60, wr_target = 8'ha0;
   logic [5:0] read_fine_offset = 6'h00, write_fine_offset = 6'h00;
   logic read_phase_late_pin, write_phase_late_pin;
   wire [7:0] upper_strobe_code, lower_strobe_code, write_data_code;
   wire [7:0] read_loop_status_count, write_loop_status_count;
   wire       read_loop_status_ovf, read_loop_status_unf, lock_wait_done;
   wire       write_loop_status_ovf, write_loop_status_unf, loop_phase_select;
   wire [3:0] t_ras_cyc, t_rc_cyc, t_rfc_cyc, t_rcd_cyc, t_rp_cyc, t_wr_cyc;
   logic [7:0] v;
   logic [5:0] offs[4] = '{6'h1f, 6'h20, 6'h1f, 6'h20};
   logic [7:0] dly[4] = '{8'h68, 8'h68, 8'hf0, 8'h10};
   logic [7:0] expc[4] = '{8'h87, 8'h48, 8'hff, 8'h00};
   // Six cycle counts per set, packed in port order from t_ras to t_wr.
   logic [23:0] tset[4] = '{24'h345111, 24'h467221, 24'h69a332, 24'h7ac332};
   int miscompares = 0, comparisons = 0;
   always #2.5 clock = ~clock;
   dsdl_top #(.LOCK_WAIT_CYC(8)) i_dsdl_top (.*);
   dsdl_phase_model i_dsdl_phase_model_rd (.clock(clock),
      .code(upper_strobe_code), .target(rd_target), .late(read_phase_late_pin));
   dsdl_phase_model i_dsdl_phase_model_wr (.clock(clock),
      .code(write_data_code), .target(wr_target), .late(write_phase_late_pin));
   task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ctl(logic en, logic ld, logic [7:0] d);
      @(posedge clock);
      loop_enable <= en;
      loop_force_load <= ld;
      load_delay <= d;
   endtask
   task automatic wait_cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #20us;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      wait_cyc(1);
      check("reset count", read_loop_status_count, 8'h80);
      check("reset flag", write_loop_status_ovf, 8'h00);
      $display("test reset done");
      ctl(1, 0, 8'h68);
      ctl(1, 1, 8'h68);
      wait_cyc(4);
      check("unlocked code", upper_strobe_code, 8'h68);
      check("write code", write_data_code, 8'h68);
      ctl(0, 1, 8'h68);
      wait_cyc(20);
      check("frozen code", lower_strobe_code, 8'h68);
      ctl(0, 1, 8'h20);
      wait_cyc(5);
      check("load while off", read_loop_status_count, 8'h68);
      $display("test unlocked done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         read_fine_offset <= offs[i];
         write_fine_offset <= offs[i];
         phase_select_bit <= i[0];
         timing_grade_select <= i[1:0];
         mobile_ddr_select <= ~i[1];
         ctl(1, 1, dly[i]);
         wait_cyc(4);
         check("read code", upper_strobe_code, expc[i]);
         check("write code", write_data_code, expc[i]);
         check("phase", loop_phase_select, i[0]);
         check("timing set", {t_ras_cyc, t_rc_cyc, t_rfc_cyc, t_rcd_cyc,
            t_rp_cyc, t_wr_cyc}, tset[i]);
      end
      $display("test offsets done");
      @(posedge clock);
      read_fine_offset <= 6'h00;
      write_fine_offset <= 6'h00;
      ctl(1, 1, 8'h80);
      wait_cyc(2);
      ctl(1, 0, 8'h80);
      wait_cyc(4);
      check("wait early", lock_wait_done, 8'h00);
      wait_cyc(8);
      check("wait done", lock_wait_done, 8'h01);
      wait_cyc(60);
      v = read_loop_status_count;
      check("read lock", v > 8'h57 && v < 8'h68, 8'h01);
      v = write_loop_status_count;
      check("write lock", v > 8'h97 && v < 8'ha8, 8'h01);
      ctl(0, 0, 8'h80);
      wait_cyc(3);
      v = read_loop_status_count;
      wait_cyc(10);
      check("freeze", read_loop_status_count, v);
      $display("test locked done");
      rd_target <= 8'hff;
      wr_target <= 8'h00;
      ctl(1, 1, 8'hfa);
      wait_cyc(2);
      ctl(1, 0, 8'hfa);
      wait_cyc(300);
      check("overflow", read_loop_status_ovf, 8'h01);
      check("bottom", write_loop_status_count, 8'h00);
      check("underflow", write_loop_status_unf, 8'h01);
      ctl(0, 0, 8'hfa);
      wait_cyc(3);
      check("ovf cleared", read_loop_status_ovf, 8'h00);
      check("unf cleared", write_loop_status_unf, 8'h00);
      $display("test saturation done");
      conclude();
   end
endmodule // testbench
